// ===== verilog/dswr_pkg.sv
package dswr_pkg;
  localparam int GPIO_W = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int WAKE_W = 6;
  localparam int SYNC_W = 5;

  // register offsets
  localparam logic [2:0] OFS_SLEEP_CTRL = 3'h0;
  localparam logic [2:0] OFS_WAKE_SRC = 3'h1;
  localparam logic [2:0] OFS_WORD0 = 3'h2;
  localparam logic [2:0] OFS_WORD1 = 3'h3;
  localparam logic [2:0] OFS_RESET_CAUSE = 3'h4;

  // field positions
  localparam int CTRL_RELEASE_BIT = 0;
  localparam int CTRL_BROWNOUT_BIT = 1;
  localparam int CTRL_REQUEST_BIT = 15;
  localparam int CAUSE_EXIT_BIT = 10;
  localparam int WS_POR = 0;
  localparam int WS_WDT = 1;
  localparam int WS_ALARM = 2;
  localparam int WS_EXTRST = 3;
  localparam int WS_INT = 4;
  localparam int WS_BOR = 5;

  // reset values
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [WAKE_W-1:0] WAKE_RESET = 6'h00;
  localparam logic [GPIO_W-1:0] DIR_RESET = 8'hff;
  localparam logic [GPIO_W-1:0] LAT_RESET = 8'h00;

  // power-on sequence length after a wake
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_TIME_NS = 256;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 7;
  localparam int WDT_CNT_W = 32;

  typedef enum logic [2:0] {
    DSWR_ACTIVE = 3'b001,
    DSWR_ASLEEP = 3'b010,
    DSWR_WAKING = 3'b100
  } dswr_state_t;
endpackage

// ===== verilog/dswr_sync.sv
`timescale 1ns/1ps
module dswr_sync #(
  parameter int W = 1
) (
  input wire logic clk, // always-on clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] async_in, // pins from outside the domain
  input wire logic [W-1:0] reset_val, // constant, masked out; reset always loads zero
  output logic [W-1:0] sync_out // two-flop synchronised copy
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] out_d;

  always_comb begin
    meta_d = async_in;
    out_d = meta_q;
  end

  // reset_val is tied to a constant at the instance
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= meta_d;
      sync_out <= out_d | (reset_val & ~reset_val);
    end
  end
endmodule

// ===== verilog/dswr_top.sv
`timescale 1ns/1ps
// Summary of operation
// - wake on por, watchdog, alarm, reset pin, interrupt
// - interrupt pin wakes if enabled, changed, polarity
// - pending interrupts cleared on sleep entry
// - wake resets core like power-on, retention kept
// - wake events during power-on sequence ignored
// - wake clears sleep request, restarts core
// - exit flag bit 10, software clears it
// - wake source captured in readable register
// - sleep brownout recorded in control bit 1
// - retained words survive deep sleep
// - pins hold direction and level while asleep
// - secondary oscillator keeps running if enabled
// - pin register writes ignored while release set
// - clearing release frees pins to live settings
// - brownout or power-on, with brownout enabled, loses retention, frees pins
// - reset pin wake keeps registers, pins reset
// - oscillator enable write waits for release clear
// - sleep entry resets the sleep watchdog
module dswr_top
  import dswr_pkg::*;
#(
  parameter int unsigned WDT_TIMEOUT_CYCLES = 525000
) (
  input wire logic clk, // always-on clock, 250 MHz
  input wire logic rstn, // always-on power-on reset, active low
  input wire logic [dswr_pkg::ADDR_W-1:0] addr, // register address
  input wire logic [dswr_pkg::DATA_W-1:0] wdata, // write data
  input wire logic we, // write strobe
  input wire logic re, // read strobe
  output logic [dswr_pkg::DATA_W-1:0] rdata, // read data, cycle after re
  input wire logic sleep_cmd, // core executes the sleep instruction
  input wire logic [dswr_pkg::GPIO_W-1:0] pin_direction, // live direction, 1 = input
  input wire logic [dswr_pkg::GPIO_W-1:0] output_latch, // live output latch
  input wire logic secondary_osc_enable, // live oscillator-control enable
  input wire logic calendar_enable, // calendar enabled
  input wire logic wake_int_enable, // interrupt enable of the wake pin
  input wire logic wake_int_polarity, // waking level of the wake pin
  input wire logic brownout_enable, // sleep brownout detector enabled
  input wire logic watchdog_enable, // sleep watchdog enabled
  input wire logic external_reset_pin_n, // external reset pin, active low
  input wire logic wake_interrupt_pin, // external interrupt pin
  input wire logic supply_por, // supply power-on event
  input wire logic brownout_trip, // sleep brownout detector
  input wire logic calendar_alarm, // calendar alarm
  output logic core_rst_n, // core reset, active low
  output logic irq_clear, // clears pending interrupts
  output logic [dswr_pkg::GPIO_W-1:0] pin_out, // pad output level
  output logic [dswr_pkg::GPIO_W-1:0] pin_oe, // pad output enable
  output logic secondary_osc_run // keeps the secondary oscillator on
);
  import dswr_pkg::*;

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;
  logic ext_n_s, int_s, por_s, bor_s, alarm_s;

  dswr_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(sync_raw),
    .reset_val(5'h00),
    .sync_out(sync_val)
  );

  assign sync_raw = {calendar_alarm, brownout_trip, supply_por, wake_interrupt_pin, external_reset_pin_n};
  // reset pin reads as asserted until the synchroniser fills; harmless, no sleep yet
  assign ext_n_s = sync_val[0];
  assign int_s = sync_val[1];
  assign por_s = sync_val[2];
  assign bor_s = sync_val[3];
  assign alarm_s = sync_val[4];

  dswr_state_t state_q, state_d;
  logic [POR_CNT_W-1:0] por_cnt_q, por_cnt_d;
  logic [WDT_CNT_W-1:0] wdt_cnt_q, wdt_cnt_d;
  logic req_q, req_d;
  logic release_q, release_d;
  logic brownout_q, brownout_d;
  logic exit_q, exit_d;
  logic [WAKE_W-1:0] wake_src_q, wake_src_d;
  logic [DATA_W-1:0] word0_q, word0_d, word1_q, word1_d;
  logic [GPIO_W-1:0] hold_dir_q, hold_dir_d, hold_lat_q, hold_lat_d;
  logic hold_secondary_osc_q, hold_secondary_osc_d;
  logic int_en_q, int_en_d, int_lvl_q, int_lvl_d;
  logic [DATA_W-1:0] rdata_d;

  logic asleep, entry, wake, loss, wdt_to, int_hit;
  logic [WAKE_W-1:0] wake_vec;

  function automatic logic hit(input logic w, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = w && (a == ofs);
  endfunction

  assign asleep = (state_q == DSWR_ASLEEP);
  assign entry = (state_q == DSWR_ACTIVE) && req_q && sleep_cmd;
  assign wdt_to = watchdog_enable && (wdt_cnt_q == WDT_CNT_W'(WDT_TIMEOUT_CYCLES - 1));
  // needs a change since entry as well as the waking level
  assign int_hit = int_en_q && (int_s != int_lvl_q) && (int_s == wake_int_polarity);
  always_comb begin
    wake_vec = WAKE_RESET;
    wake_vec[WS_POR] = por_s;
    wake_vec[WS_WDT] = wdt_to;
    wake_vec[WS_ALARM] = alarm_s && calendar_enable;
    wake_vec[WS_EXTRST] = !ext_n_s;
    wake_vec[WS_INT] = int_hit;
    wake_vec[WS_BOR] = bor_s && brownout_enable;
  end
  assign wake = asleep && (|wake_vec);
  assign loss = asleep && brownout_enable && (por_s || bor_s);

  always_comb begin
    state_d = state_q;
    por_cnt_d = por_cnt_q;
    wdt_cnt_d = wdt_cnt_q;
    req_d = req_q;
    release_d = release_q;
    brownout_d = brownout_q;
    exit_d = exit_q;
    wake_src_d = wake_src_q;
    word0_d = word0_q;
    word1_d = word1_q;
    hold_dir_d = hold_dir_q;
    hold_lat_d = hold_lat_q;
    hold_secondary_osc_d = hold_secondary_osc_q;
    int_en_d = int_en_q;
    int_lvl_d = int_lvl_q;
    // software writes first, so hardware sets below win over clears
    if (hit(we, addr, OFS_SLEEP_CTRL)) begin
      req_d = wdata[CTRL_REQUEST_BIT];
      if (!wdata[CTRL_RELEASE_BIT]) begin
        release_d = 1'b0;
      end
      if (!wdata[CTRL_BROWNOUT_BIT]) begin
        brownout_d = 1'b0;
      end
    end
    if (hit(we, addr, OFS_WAKE_SRC)) begin
      wake_src_d = wake_src_q & ~wdata[WAKE_W-1:0];
    end
    if (hit(we, addr, OFS_WORD0)) begin
      word0_d = wdata;
    end
    if (hit(we, addr, OFS_WORD1)) begin
      word1_d = wdata;
    end
    if (hit(we, addr, OFS_RESET_CAUSE) && wdata[CAUSE_EXIT_BIT]) begin
      exit_d = 1'b0;
    end
    case (state_q)
      DSWR_ACTIVE: begin
        if (entry) begin
          state_d = DSWR_ASLEEP;
          wdt_cnt_d = '0;
          release_d = 1'b1;
          hold_dir_d = pin_direction;
          hold_lat_d = output_latch;
          hold_secondary_osc_d = secondary_osc_enable;
          int_en_d = wake_int_enable;
          int_lvl_d = int_s;
        end
      end
      DSWR_ASLEEP: begin
        if (watchdog_enable && !wdt_to) begin
          wdt_cnt_d = wdt_cnt_q + WDT_CNT_W'(1);
        end
        if (bor_s && brownout_enable) begin
          brownout_d = 1'b1;
        end
        if (wake) begin
          state_d = DSWR_WAKING;
          por_cnt_d = '0;
          req_d = 1'b0;
          exit_d = 1'b1;
          wake_src_d = wake_src_q | wake_vec;
          if (!ext_n_s) begin
            hold_dir_d = DIR_RESET;
            hold_lat_d = LAT_RESET;
          end
        end
        if (loss) begin
          release_d = 1'b0;
          word0_d = WORD_RESET;
          word1_d = WORD_RESET;
        end
      end
      DSWR_WAKING: begin
        // wake sources not sampled here: late events vanish
        if (por_cnt_q == POR_CNT_W'(POR_CYCLES - 1)) begin
          state_d = DSWR_ACTIVE;
        end else begin
          por_cnt_d = por_cnt_q + POR_CNT_W'(1);
        end
      end
      default: begin
        state_d = DSWR_ACTIVE;
      end
    endcase
  end

  always_comb begin
    rdata_d = '0;
    if (re) begin
      case (addr)
        OFS_SLEEP_CTRL: begin
          rdata_d[CTRL_REQUEST_BIT] = req_q;
          rdata_d[CTRL_BROWNOUT_BIT] = brownout_q;
          rdata_d[CTRL_RELEASE_BIT] = release_q;
        end
        OFS_WAKE_SRC: rdata_d[WAKE_W-1:0] = wake_src_q;
        OFS_WORD0: rdata_d = word0_q;
        OFS_WORD1: rdata_d = word1_q;
        OFS_RESET_CAUSE: rdata_d[CAUSE_EXIT_BIT] = exit_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= DSWR_ACTIVE;
      por_cnt_q <= '0;
      wdt_cnt_q <= '0;
      req_q <= 1'b0;
      release_q <= 1'b0;
      brownout_q <= 1'b0;
      exit_q <= 1'b0;
      wake_src_q <= WAKE_RESET;
      word0_q <= WORD_RESET;
      word1_q <= WORD_RESET;
      hold_dir_q <= DIR_RESET;
      hold_lat_q <= LAT_RESET;
      hold_secondary_osc_q <= 1'b0;
      int_en_q <= 1'b0;
      int_lvl_q <= 1'b0;
      rdata <= '0;
    end else begin
      state_q <= state_d;
      por_cnt_q <= por_cnt_d;
      wdt_cnt_q <= wdt_cnt_d;
      req_q <= req_d;
      release_q <= release_d;
      brownout_q <= brownout_d;
      exit_q <= exit_d;
      wake_src_q <= wake_src_d;
      word0_q <= word0_d;
      word1_q <= word1_d;
      hold_dir_q <= hold_dir_d;
      hold_lat_q <= hold_lat_d;
      hold_secondary_osc_q <= hold_secondary_osc_d;
      int_en_q <= int_en_d;
      int_lvl_q <= int_lvl_d;
      rdata <= rdata_d;
    end
  end

  assign core_rst_n = (state_q == DSWR_ACTIVE);
  assign irq_clear = entry;
  // live pin settings reach the pads only once release is clear
  assign pin_out = release_q ? hold_lat_q : output_latch;
  assign pin_oe = release_q ? ~hold_dir_q : ~pin_direction;
  assign secondary_osc_run = release_q ? hold_secondary_osc_q : secondary_osc_enable;

  property p_exit_flag;
    @(posedge clk) disable iff (!rstn) wake |=> exit_q && !req_q && !core_rst_n;
  endproperty
  a_exit_flag: assert property (p_exit_flag) else $error("exit flag or request wrong after wake");

  property p_por_hold;
    @(posedge clk) disable iff (!rstn) wake |=> (!core_rst_n) [*8];
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core left reset too early");

  property p_ignore_late;
    @(posedge clk) disable iff (!rstn)
      (state_q == DSWR_WAKING) |=> (wake_src_q & ~$past(wake_src_q)) == WAKE_RESET;
  endproperty
  a_ignore_late: assert property (p_ignore_late) else $error("wake source set during power-on");

  property p_irq_clear;
    @(posedge clk) disable iff (!rstn) entry |-> irq_clear ##1 (state_q == DSWR_ASLEEP);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("entry without interrupt clear");

  property p_pin_hold;
    @(posedge clk) disable iff (!rstn) release_q |-> pin_oe == ~hold_dir_q && pin_out == hold_lat_q;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins not held under release");

  property p_pin_free;
    @(posedge clk) disable iff (!rstn) !release_q |-> pin_oe == ~pin_direction && pin_out == output_latch;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("pins not free without release");

  property p_bor_loss;
    @(posedge clk) disable iff (!rstn) loss |=> !release_q && word0_q == WORD_RESET && word1_q == WORD_RESET;
  endproperty
  a_bor_loss: assert property (p_bor_loss) else $error("retention kept after brownout");

  property p_osc_hold;
    @(posedge clk) disable iff (!rstn) release_q |-> secondary_osc_run == hold_secondary_osc_q;
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable leaked");

  property p_wdt_clear;
    @(posedge clk) disable iff (!rstn) entry |=> wdt_cnt_q == '0;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared at entry");

  property p_retain;
    @(posedge clk) disable iff (!rstn) (asleep && !loss && !we) |=> $stable(word0_q) && $stable(word1_q);
  endproperty
  a_retain: assert property (p_retain) else $error("retained word changed in sleep");

  property p_ext_wake;
    @(posedge clk) disable iff (!rstn) (wake && !ext_n_s && !loss) |=> release_q && hold_dir_q == DIR_RESET;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("reset pin wake handling wrong");
endmodule

// ===== tb/dswr_pins_model.sv
`timescale 1ns/1ps
module dswr_pins_model (
  input wire logic clk, // bench clock
  input wire logic [5:0] ev, // one-cycle event request, one bit a source
  output logic supply_por, // supply power-on
  output logic calendar_alarm, // calendar alarm
  output logic external_reset_pin_n, // reset pin, pulled up when idle
  output logic wake_interrupt_pin, // interrupt pin
  output logic brownout_trip // brownout detector
);
  logic [5:0] act = 6'h00;
  int cnt = 0;
  // pulses stretched to 5 cycles so the 2-flop synchronisers see them
  always @(posedge clk) begin
    if (ev != 6'h00) begin
      act <= ev;
      cnt <= 4;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      act <= 6'h00;
    end
  end
  assign supply_por = act[0];
  assign calendar_alarm = act[2];
  assign external_reset_pin_n = ~act[3];
  assign wake_interrupt_pin = act[4];
  assign brownout_trip = act[5];
endmodule

// ===== tb/dswr_top_tb.sv
`timescale 1ns/1ps
module dswr_top_tb;
  import dswr_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic we = 0, re = 0, sleep_cmd = 0;
  logic [GPIO_W-1:0] dir = DIR_RESET, lat = LAT_RESET, hdir, hlat, pin_out, pin_oe;
  logic osc = 0, cal_en = 1, int_en = 1, int_pol = 1, bor_en = 0, wdt_en = 0;
  logic [5:0] ev = 6'h00;
  logic [DATA_W-1:0] rdata, w0, w1, got;
  logic core_rst_n, irq_clear, osc_run, por, bor, alarm, xrst_n, intp;
  int n_mismatch = 0, n_tests = 0, cyc;
  localparam int WDT_TO = 20;
  always #2 clk = ~clk;
  dswr_top #(.WDT_TIMEOUT_CYCLES(WDT_TO)) uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we),
    .re(re), .rdata(rdata), .sleep_cmd(sleep_cmd), .pin_direction(dir), .output_latch(lat),
    .secondary_osc_enable(osc), .calendar_enable(cal_en), .wake_int_enable(int_en),
    .wake_int_polarity(int_pol), .brownout_enable(bor_en), .watchdog_enable(wdt_en),
    .external_reset_pin_n(xrst_n), .wake_interrupt_pin(intp), .supply_por(por), .brownout_trip(bor),
    .calendar_alarm(alarm), .core_rst_n(core_rst_n), .irq_clear(irq_clear), .pin_out(pin_out),
    .pin_oe(pin_oe), .secondary_osc_run(osc_run));
  dswr_pins_model partner (.clk(clk), .ev(ev), .supply_por(por), .calendar_alarm(alarm),
    .external_reset_pin_n(xrst_n), .wake_interrupt_pin(intp), .brownout_trip(bor));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 got = rdata;
  endtask
  // only driven pins are compared for level; inputs must be undriven
  task automatic pins(input logic [GPIO_W-1:0] d, input logic [GPIO_W-1:0] l, input string m);
    #1 chk({8'h00, pin_oe}, {8'h00, ~d}, m);
    chk({8'h00, pin_out & pin_oe}, {8'h00, l & ~d}, m);
  endtask
  function automatic logic [DATA_W-1:0] ws_exp(input int k);
    int b [6] = '{WS_POR, WS_WDT, WS_ALARM, WS_EXTRST, WS_INT, WS_BOR};
    return 16'h0001 << b[k];
  endfunction
  // edges from the event edge to the wake edge: two sync flops plus the wake edge,
  // or the watchdog timeout counted from entry, two edges before the event edge
  function automatic int por_lag(input int k);
    return (k == 1) ? WDT_TO - 2 : 3;
  endfunction
  initial begin
    #100000;
    n_mismatch++;
    $display("[FAIL] %0t run did not finish in time", $time);
    stop_test();
  end
  initial begin
    void'($urandom(61));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(a[2:0]);
      chk(got, 16'h0000, "value after power-on");
    end
    // k: 0 power-on, 1 watchdog, 2 alarm, 3 reset pin, 4 interrupt pin, 5 brownout
    for (int k = 0; k < 6; k++) begin
      w0 = 16'($urandom());
      w1 = 16'($urandom());
      wr(OFS_WORD0, w0);
      wr(OFS_WORD1, w1);
      @(posedge clk);
      dir <= 8'($urandom());
      lat <= 8'($urandom());
      osc <= 1'b1;
      wdt_en <= (k == 1);
      bor_en <= (k == 5);
      cal_en <= (k != 4);
      int_en <= (k != 2);
      wr(OFS_SLEEP_CTRL, 16'h8000);
      hdir = dir;
      hlat = lat;
      sleep_cmd <= 1'b1;
      #1 chk({15'h0000, irq_clear}, 16'h0001, "irq clear at entry");
      @(posedge clk);
      sleep_cmd <= 1'b0;
      dir <= ~hdir;
      lat <= ~hlat;
      osc <= 1'b0;
      pins(hdir, hlat, "pins held asleep");
      chk({15'h0000, osc_run}, 16'h0001, "osc kept asleep");
      chk({15'h0000, core_rst_n}, 16'h0000, "core held asleep");
      @(posedge clk);
      if (k != 1) begin
        // alarm and interrupt pin together; only the enabled one may wake
        ev <= (k == 2 || k == 4) ? 6'h14 : 6'(1 << k);
      end
      @(posedge clk);
      ev <= 6'h00;
      if (k == 5) begin
        repeat (5) @(posedge clk);
        pins(~hdir, ~hlat, "pins freed on brownout");
      end
      // late alarm falls inside the power-on sequence and must not be recorded
      repeat ((k == 1) ? 30 : (k == 5) ? 7 : 12) @(posedge clk);
      ev <= 6'h04;
      @(posedge clk);
      ev <= 6'h00;
      // cyc counts edges since the event edge, sampled 1 ns after each edge
      cyc = (k == 1) ? 31 : 13;
      while (core_rst_n !== 1'b1 && cyc < 400) begin
        @(posedge clk);
        #1 cyc++;
      end
      chk(16'(cyc), 16'(POR_CYCLES + por_lag(k)), "power-on sequence length");
      rd(OFS_WAKE_SRC);
      chk(got, ws_exp(k), "wake source");
      rd(OFS_SLEEP_CTRL);
      chk(got, (k == 5) ? 16'h0002 : 16'h0001, "control after wake");
      rd(OFS_RESET_CAUSE);
      chk(got, 16'h0400, "exit flag");
      rd(OFS_WORD0);
      chk(got, (k == 5) ? 16'h0000 : w0, "word0 kept");
      rd(OFS_WORD1);
      chk(got, (k == 5) ? 16'h0000 : w1, "word1 kept");
      if (k != 5) begin
        if (k == 3) begin
          pins(8'hff, 8'h00, "pins in reset state");
        end else begin
          pins(hdir, hlat, "pins held after wake");
        end
        chk({15'h0000, osc_run}, 16'h0001, "osc enable write deferred");
        @(posedge clk);
        osc <= 1'b1;
      end
      wr(OFS_WAKE_SRC, 16'h003f);
      wr(OFS_RESET_CAUSE, 16'h0400);
      wr(OFS_SLEEP_CTRL, 16'h0000);
      pins(~hdir, ~hlat, "pins released");
      chk({15'h0000, osc_run}, {15'h0000, k != 5}, "osc follows live enable");
      rd(OFS_WAKE_SRC);
      chk(got, 16'h0000, "wake source cleared");
      rd(OFS_RESET_CAUSE);
      chk(got, 16'h0000, "exit flag cleared");
      $display("test %0d done", k);
    end
    stop_test();
  end
endmodule
